// [cis_dec_if.sv]
// decoded instruction fields between decoder and executor
`timescale 1ns/100ps
interface cis_dec_if;
  import cis_pkg::*;
  cis_op_t op;
  logic [ACC_W-1:0] lit8;
  logic [LIT11_W-1:0] lit11;
  logic [FADDR_W-1:0] faddr;
  logic dsel;
  modport dec (output op, lit8, lit11, faddr, dsel);
  modport exe (input op, lit8, lit11, faddr, dsel);
endinterface

// [cis_decoder.sv]
// instruction word decoder for the executor
`timescale 1ns/100ps
module cis_decoder (
  input wire logic [cis_pkg::INSTR_W-1:0] i_instr,
  cis_dec_if.dec dec
);
  import cis_pkg::*;

  // ----------------------------------------------------------------
  // field extraction and opcode match
  // ----------------------------------------------------------------
  always_comb begin
    dec.lit8 = i_instr[ACC_W-1:0];
    dec.lit11 = i_instr[LIT11_W-1:0];
    dec.faddr = i_instr[FADDR_W-1:0];
    dec.dsel = i_instr[DSEL_BIT];
    if ((i_instr & MASK_JUMP) == CODE_JUMP) begin
      dec.op = CIS_OP_JUMP;
    end else if ((i_instr & MASK_BYTE) == CODE_ORL) begin
      dec.op = CIS_OP_ORL;
    end else if ((i_instr & MASK_BYTE) == CODE_INC) begin
      dec.op = CIS_OP_INC;
    end else if ((i_instr & MASK_BYTE) == CODE_IORF) begin
      dec.op = CIS_OP_IORF;
    end else if ((i_instr & MASK_BYTE) == CODE_COPY) begin
      dec.op = CIS_OP_COPY;
    end else if ((i_instr & MASK_LDL) == CODE_LDL) begin
      dec.op = CIS_OP_LDL;
    end else if ((i_instr & MASK_FULL) == CODE_RETI) begin
      dec.op = CIS_OP_RETI;
    end else if ((i_instr & MASK_FULL) == CODE_RET) begin
      dec.op = CIS_OP_RET;
    end else if ((i_instr & MASK_STORE) == CODE_STORE) begin
      dec.op = CIS_OP_STORE;
    end else begin
      dec.op = CIS_OP_NOP;
    end
  end

endmodule // cis_decoder

// [cis_exec.sv]
// executor for a subset of an 8-bit core instruction set
`timescale 1ns/100ps
module cis_exec (
  input wire logic I_CLK_SYS,
  input wire logic I_NRST,
  input wire logic [cis_pkg::INSTR_W-1:0] I_INSTR,
  input wire logic I_INSTR_VALID,
  output logic O_INSTR_READY,
  input wire logic [cis_pkg::PAGE_W-1:0] I_PAGE_LATCH,
  input wire logic [cis_pkg::PC_W-1:0] I_STACK_TOP,
  output logic O_STACK_POP,
  input wire logic I_GIE_CLR,
  output logic [cis_pkg::FADDR_W-1:0] O_FILE_RADDR,
  input wire logic [cis_pkg::ACC_W-1:0] I_FILE_RDATA,
  output logic O_FILE_WE,
  output logic [cis_pkg::FADDR_W-1:0] O_FILE_WADDR,
  output logic [cis_pkg::ACC_W-1:0] O_FILE_WDATA,
  output logic [cis_pkg::PC_W-1:0] O_PC,
  output logic [cis_pkg::ACC_W-1:0] O_ACC,
  output logic O_ZERO,
  output logic O_GIE
);
  import cis_pkg::*;

  cis_dec_if u_if ();

  cis_decoder u_dec (
    .i_instr(I_INSTR),
    .dec(u_if.dec)
  );

  cis_state_t state_ff, nxt_state;
  logic [PC_W-1:0] pc_ff, nxt_pc;
  logic [ACC_W-1:0] acc_ff, nxt_acc;
  logic zero_ff, nxt_zero;
  logic gie_ff, nxt_gie;
  logic fwe_ff, nxt_fwe;
  logic [FADDR_W-1:0] fwaddr_ff, nxt_fwaddr;
  logic [ACC_W-1:0] fwdata_ff, nxt_fwdata;
  logic pop_ff, nxt_pop;
  logic accept;
  logic [ACC_W-1:0] file_val;
  logic [ACC_W-1:0] res;

  // ----------------------------------------------------------------
  // handshake and file read with write bypass
  // ----------------------------------------------------------------
  assign O_INSTR_READY = (state_ff == CIS_ST_EXEC);
  assign accept = I_INSTR_VALID && O_INSTR_READY;
  assign O_FILE_RADDR = u_if.faddr;
  assign file_val = (fwe_ff && (fwaddr_ff == u_if.faddr)) ? fwdata_ff : I_FILE_RDATA;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = CIS_ST_EXEC;
    nxt_pc = pc_ff;
    nxt_acc = acc_ff;
    nxt_zero = zero_ff;
    nxt_gie = I_GIE_CLR ? 1'b0 : gie_ff;
    nxt_fwe = 1'b0;
    nxt_fwaddr = fwaddr_ff;
    nxt_fwdata = fwdata_ff;
    nxt_pop = 1'b0;
    res = ACC_ZERO;
    if (accept) begin
      nxt_pc = pc_ff + PC_STEP;
      case (u_if.op)
        CIS_OP_JUMP: begin
          nxt_pc = {I_PAGE_LATCH[PAGE_HI:PAGE_LO], u_if.lit11};
          nxt_state = CIS_ST_FLUSH;
        end
        CIS_OP_ORL: begin
          res = acc_ff | u_if.lit8;
          nxt_acc = res;
          nxt_zero = (res == ACC_ZERO);
        end
        CIS_OP_INC, CIS_OP_IORF, CIS_OP_COPY: begin
          if (u_if.op == CIS_OP_INC) begin
            res = file_val + ACC_ONE;
          end else if (u_if.op == CIS_OP_IORF) begin
            res = acc_ff | file_val;
          end else begin
            res = file_val;
          end
          nxt_zero = (res == ACC_ZERO);
          if (u_if.dsel) begin
            nxt_fwe = 1'b1;
            nxt_fwaddr = u_if.faddr;
            nxt_fwdata = res;
          end else begin
            nxt_acc = res;
          end
        end
        CIS_OP_LDL: begin
          nxt_acc = u_if.lit8;
        end
        CIS_OP_RETI: begin
          nxt_pc = I_STACK_TOP;
          nxt_gie = 1'b1;
          nxt_pop = 1'b1;
          nxt_state = CIS_ST_FLUSH;
        end
        CIS_OP_RET: begin
          nxt_pc = I_STACK_TOP;
          nxt_pop = 1'b1;
          nxt_state = CIS_ST_FLUSH;
        end
        CIS_OP_STORE: begin
          nxt_fwe = 1'b1;
          nxt_fwaddr = u_if.faddr;
          nxt_fwdata = acc_ff;
        end
        default: begin
          res = ACC_ZERO;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      state_ff <= CIS_ST_EXEC;
      pc_ff <= PC_RST;
      acc_ff <= ACC_RST;
      zero_ff <= 1'b0;
      gie_ff <= 1'b0;
      fwe_ff <= 1'b0;
      fwaddr_ff <= FADDR_RST;
      fwdata_ff <= ACC_RST;
      pop_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      pc_ff <= nxt_pc;
      acc_ff <= nxt_acc;
      zero_ff <= nxt_zero;
      gie_ff <= nxt_gie;
      fwe_ff <= nxt_fwe;
      fwaddr_ff <= nxt_fwaddr;
      fwdata_ff <= nxt_fwdata;
      pop_ff <= nxt_pop;
    end
  end

  assign O_PC = pc_ff;
  assign O_ACC = acc_ff;
  assign O_ZERO = zero_ff;
  assign O_GIE = gie_ff;
  assign O_FILE_WE = fwe_ff;
  assign O_FILE_WADDR = fwaddr_ff;
  assign O_FILE_WDATA = fwdata_ff;
  assign O_STACK_POP = pop_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_jump_low_bits: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    accept && u_if.op == CIS_OP_JUMP |=> O_PC[LIT11_W-1:0] == $past(u_if.lit11))
    else $error("jump low bits wrong");

  a_jump_page_bits: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    accept && u_if.op == CIS_OP_JUMP
    |=> O_PC[PC_W-1:LIT11_W] == $past(I_PAGE_LATCH[PAGE_HI:PAGE_LO]))
    else $error("jump page bits wrong");

  a_jump_two_cycles: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    accept && u_if.op == CIS_OP_JUMP
    |=> !O_INSTR_READY && $stable(O_ZERO) ##1 O_INSTR_READY)
    else $error("jump not two cycles");

  a_or_literal: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    accept && u_if.op == CIS_OP_ORL
    |=> O_ACC == ($past(O_ACC) | $past(u_if.lit8)) && O_ZERO == (O_ACC == ACC_ZERO))
    else $error("or literal wrong");

  a_inc_dest: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    accept && u_if.op == CIS_OP_INC
    |=> (O_FILE_WE ? O_FILE_WDATA : O_ACC) == $past(file_val) + ACC_ONE
        && O_FILE_WE == $past(u_if.dsel))
    else $error("increment wrong");

  a_or_file_dest: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    accept && u_if.op == CIS_OP_IORF && u_if.dsel
    |=> O_FILE_WE && O_FILE_WDATA == ($past(O_ACC) | $past(file_val)) && $stable(O_ACC))
    else $error("or file wrong");

  a_copy_zero: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    accept && u_if.op == CIS_OP_COPY |=> O_ZERO == ($past(file_val) == ACC_ZERO))
    else $error("copy zero wrong");

  a_load_literal: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    accept && u_if.op == CIS_OP_LDL |=> O_ACC == $past(u_if.lit8) && $stable(O_ZERO))
    else $error("load literal wrong");

  a_reti_gie: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    accept && u_if.op == CIS_OP_RETI |=> O_GIE && O_PC == $past(I_STACK_TOP) && O_STACK_POP)
    else $error("return from interrupt wrong");

  a_store_write: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    accept && u_if.op == CIS_OP_STORE
    |=> O_FILE_WE && O_FILE_WDATA == $past(O_ACC) && O_FILE_WADDR == $past(u_if.faddr)
        && $stable(O_ZERO))
    else $error("store wrong");

  a_return_pop: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    accept && u_if.op == CIS_OP_RET
    |=> O_STACK_POP && O_PC == $past(I_STACK_TOP) && !O_INSTR_READY ##1 !O_STACK_POP)
    else $error("return wrong");

  a_zero_from_acc: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    accept && !u_if.dsel && (u_if.op == CIS_OP_INC || u_if.op == CIS_OP_IORF)
    |=> O_ZERO == (O_ACC == ACC_ZERO))
    else $error("zero flag wrong");

  a_single_cycle: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    accept && u_if.op == CIS_OP_NOP
    |=> O_INSTR_READY && O_PC == $past(O_PC) + PC_STEP && $stable(O_ACC) && !O_FILE_WE)
    else $error("single cycle step wrong");

endmodule // cis_exec

// [cis_exec_tb.sv]
// self-checking testbench for the instruction subset executor
`timescale 1ns/100ps
module cis_exec_tb;
  import cis_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic I_CLK_SYS;
  logic I_NRST;
  logic [INSTR_W-1:0] I_INSTR;
  logic I_INSTR_VALID;
  logic O_INSTR_READY;
  logic [PAGE_W-1:0] I_PAGE_LATCH;
  logic [PC_W-1:0] I_STACK_TOP;
  logic O_STACK_POP;
  logic I_GIE_CLR;
  logic [FADDR_W-1:0] O_FILE_RADDR;
  logic [ACC_W-1:0] I_FILE_RDATA;
  logic O_FILE_WE;
  logic [FADDR_W-1:0] O_FILE_WADDR;
  logic [ACC_W-1:0] O_FILE_WDATA;
  logic [PC_W-1:0] O_PC;
  logic [ACC_W-1:0] O_ACC;
  logic O_ZERO;
  logic O_GIE;
  logic [ACC_W-1:0] fmem [128];
  int miscompares = 0;
  int checks_done = 0;

  cis_exec i_dut (.I_CLK_SYS(I_CLK_SYS), .I_NRST(I_NRST), .I_INSTR(I_INSTR),
    .I_INSTR_VALID(I_INSTR_VALID), .O_INSTR_READY(O_INSTR_READY),
    .I_PAGE_LATCH(I_PAGE_LATCH), .I_STACK_TOP(I_STACK_TOP), .O_STACK_POP(O_STACK_POP),
    .I_GIE_CLR(I_GIE_CLR), .O_FILE_RADDR(O_FILE_RADDR), .I_FILE_RDATA(I_FILE_RDATA),
    .O_FILE_WE(O_FILE_WE), .O_FILE_WADDR(O_FILE_WADDR), .O_FILE_WDATA(O_FILE_WDATA),
    .O_PC(O_PC), .O_ACC(O_ACC), .O_ZERO(O_ZERO), .O_GIE(O_GIE));

  // ----------------------------------------------------------------
  // clock and file register model
  // ----------------------------------------------------------------
  initial begin
    I_CLK_SYS = 1'b0;
    forever #12.5 I_CLK_SYS = ~I_CLK_SYS;
  end

  assign I_FILE_RDATA = fmem[O_FILE_RADDR];

  always @(posedge I_CLK_SYS) begin
    if (O_FILE_WE === 1'b1) fmem[O_FILE_WADDR] <= O_FILE_WDATA;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic close_out;
    begin
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
        $display("ALL CHECKS OK");
      end else begin
        $display("CHECKS NOT OK");
      end
      $finish;
    end
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    begin
      checks_done++;
      if (got !== exp) begin
        miscompares++;
        $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask

  // present a word at a falling edge, wait for acceptance, return at next falling edge
  task automatic issue(input logic [INSTR_W-1:0] w);
    int n;
    begin
      n = 0;
      I_INSTR = w;
      I_INSTR_VALID = 1'b1;
      while (O_INSTR_READY !== 1'b1 && n < 8) begin
        @(negedge I_CLK_SYS);
        n++;
      end
      if (n == 8) begin
        miscompares++;
        close_out;
      end
      @(posedge I_CLK_SYS);
      @(negedge I_CLK_SYS);
    end
  endtask

  task automatic idle;
    begin
      I_INSTR_VALID = 1'b0;
      @(negedge I_CLK_SYS);
    end
  endtask

  task automatic st(input logic [15:0] pc, input logic [15:0] acc, input logic [15:0] z);
    begin
      chk(O_PC, pc);
      chk(O_ACC, acc);
      chk(O_ZERO, z);
    end
  endtask

  task automatic wr(input logic [15:0] adr, input logic [15:0] dat);
    begin
      chk(O_FILE_WE, 1);
      chk(O_FILE_WADDR, adr);
      chk(O_FILE_WDATA, dat);
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    for (int i = 0; i < 128; i++) fmem[i] = 8'(i);
    I_NRST = 1'b0;
    I_INSTR = 14'h0000;
    I_INSTR_VALID = 1'b0;
    I_PAGE_LATCH = 8'h00;
    I_STACK_TOP = 13'h0000;
    I_GIE_CLR = 1'b0;
    repeat (3) @(negedge I_CLK_SYS);
    I_NRST = 1'b1;
    st(0, 0, 0);
    chk(O_GIE, 0);
    chk(O_INSTR_READY, 1);
    chk(O_FILE_WE, 0);
    chk(O_STACK_POP, 0);
    issue(14'h3000);
    st(1, 0, 0);
    issue(14'h3800);
    st(2, 0, 1);
    issue(14'h305a);
    st(3, 16'h5a, 1);
    issue(14'h38a5);
    st(4, 16'hff, 0);
    issue(14'h00ff);
    wr(16'h7f, 16'hff);
    st(5, 16'hff, 0);
    issue(14'h0aff);
    wr(16'h7f, 16'h00);
    st(6, 16'hff, 1);
    issue(14'h0a7f);
    chk(O_FILE_WE, 0);
    st(7, 16'h01, 0);
    issue(14'h087f);
    st(8, 16'h00, 1);
    issue(14'h3003);
    issue(14'h0885);
    chk(O_FILE_RADDR, 16'h05);
    wr(16'h05, 16'h05);
    st(16'h0a, 16'h03, 0);
    issue(14'h0410);
    chk(O_FILE_RADDR, 16'h10);
    st(16'h0b, 16'h13, 0);
    issue(14'h0490);
    wr(16'h10, 16'h13);
    st(16'h0c, 16'h13, 0);
    I_PAGE_LATCH = 8'h18;
    issue(14'h2fff);
    st(16'h1fff, 16'h13, 0);
    chk(O_INSTR_READY, 0);
    issue(14'h0000);
    st(16'h0000, 16'h13, 0);
    I_PAGE_LATCH = 8'he8;
    issue(14'h2800);
    chk(O_PC, 16'h0800);
    I_STACK_TOP = 13'h1234;
    issue(14'h0008);
    chk(O_PC, 16'h1234);
    chk(O_STACK_POP, 1);
    chk(O_INSTR_READY, 0);
    chk(O_GIE, 0);
    idle;
    chk(O_STACK_POP, 0);
    chk(O_PC, 16'h1234);
    I_STACK_TOP = 13'h0abc;
    I_GIE_CLR = 1'b1;
    issue(14'h0009);
    chk(O_PC, 16'h0abc);
    chk(O_GIE, 1);
    chk(O_STACK_POP, 1);
    chk(O_ZERO, 0);
    issue(14'h0000);
    chk(O_GIE, 0);
    st(16'h0abd, 16'h13, 0);
    idle;
    // mid-run reset from a non-reset state
    I_GIE_CLR = 1'b0;
    I_NRST = 1'b0;
    idle;
    st(0, 0, 0);
    chk(O_GIE, 0);
    chk(O_INSTR_READY, 1);
    chk(O_FILE_WE, 0);
    chk(O_STACK_POP, 0);
    I_NRST = 1'b1;
    issue(14'h3042);
    st(1, 16'h42, 0);
    idle;
    close_out;
  end
endmodule // cis_exec_tb

// [cis_pkg.sv]
// constants, opcode patterns and types for the instruction subset executor
package cis_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int INSTR_W = 14;
  localparam int PC_W = 13;
  localparam int ACC_W = 8;
  localparam int FADDR_W = 7;
  localparam int LIT11_W = 11;
  localparam int PAGE_W = 8;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PAGE_HI = 4;
  localparam int PAGE_LO = 3;
  localparam int DSEL_BIT = 7;

  // ----------------------------------------------------------------
  // reset and step values
  // ----------------------------------------------------------------
  localparam logic [PC_W-1:0] PC_RST = 13'h0000;
  localparam logic [PC_W-1:0] PC_STEP = 13'h0001;
  localparam logic [ACC_W-1:0] ACC_RST = 8'h00;
  localparam logic [ACC_W-1:0] ACC_ONE = 8'h01;
  localparam logic [ACC_W-1:0] ACC_ZERO = 8'h00;
  localparam logic [FADDR_W-1:0] FADDR_RST = 7'h00;

  // ----------------------------------------------------------------
  // opcode masks and match values
  // ----------------------------------------------------------------
  localparam logic [INSTR_W-1:0] MASK_JUMP = 14'h3800;
  localparam logic [INSTR_W-1:0] CODE_JUMP = 14'h2800;
  localparam logic [INSTR_W-1:0] MASK_BYTE = 14'h3f00;
  localparam logic [INSTR_W-1:0] CODE_ORL = 14'h3800;
  localparam logic [INSTR_W-1:0] CODE_INC = 14'h0a00;
  localparam logic [INSTR_W-1:0] CODE_IORF = 14'h0400;
  localparam logic [INSTR_W-1:0] CODE_COPY = 14'h0800;
  localparam logic [INSTR_W-1:0] MASK_LDL = 14'h3c00;
  localparam logic [INSTR_W-1:0] CODE_LDL = 14'h3000;
  localparam logic [INSTR_W-1:0] MASK_FULL = 14'h3fff;
  localparam logic [INSTR_W-1:0] CODE_RETI = 14'h0009;
  localparam logic [INSTR_W-1:0] CODE_RET = 14'h0008;
  localparam logic [INSTR_W-1:0] MASK_STORE = 14'h3f80;
  localparam logic [INSTR_W-1:0] CODE_STORE = 14'h0080;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CIS_OP_NOP, CIS_OP_JUMP, CIS_OP_ORL, CIS_OP_INC, CIS_OP_IORF,
    CIS_OP_COPY, CIS_OP_LDL, CIS_OP_RETI, CIS_OP_RET, CIS_OP_STORE
  } cis_op_t;

  typedef enum logic {CIS_ST_EXEC, CIS_ST_FLUSH} cis_state_t;

endpackage
